// [shared/ubrg_pkg.sv]
// Shared constants and types for the serial port baud rate generator.
package ubrg_pkg;

  // ---------------------------------------------------------------
  // Widths and division constants
  // ---------------------------------------------------------------
  localparam int unsigned CD_W         = 16;
  localparam int unsigned PRESCALE_DIV = 8;
  localparam int unsigned OVS_W        = 4;
  localparam logic [3:0]  OVS_LAST_X16 = 4'hF;
  localparam logic [3:0]  OVS_LAST_X8  = 4'h7;
  localparam logic [15:0] CD_OFF       = 16'h0000;
  localparam logic [15:0] CD_BYPASS    = 16'h0001;
  localparam logic [15:0] CD_STEP      = 16'h0001;

  // ---------------------------------------------------------------
  // Serial clock ceiling in peripheral interface mode
  // ---------------------------------------------------------------
  localparam int unsigned SPI_MIN_CYC  = 4;
  localparam int unsigned GAP_W        = 3;
  localparam logic [2:0]  GAP_READY    = 3'(SPI_MIN_CYC - 1);
  localparam logic [2:0]  GAP_STEP     = 3'h1;
  localparam logic [2:0]  GAP_RESET    = 3'h0;

  // ---------------------------------------------------------------
  // Clock source selection and operating mode
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    UBRG_SRC_MCK = 2'b00,
    UBRG_SRC_DIV = 2'b01,
    UBRG_SRC_RSV = 2'b10,
    UBRG_SRC_EXT = 2'b11
  } ubrg_src_t;

  typedef enum logic [1:0] {
    UBRG_MODE_ASYNC = 2'b00,
    UBRG_MODE_SYNC  = 2'b01,
    UBRG_MODE_SPI   = 2'b10,
    UBRG_MODE_RSV   = 2'b11
  } ubrg_mode_t;

  // Contents of the serial mode register and baud divider register.
  typedef struct packed {
    ubrg_src_t         clock_source_select;
    ubrg_mode_t        mode;
    logic              over;
    logic [CD_W-1:0]   divide_count;
  } ubrg_cfg_t;

  localparam ubrg_cfg_t CFG_RESET = '{
    clock_source_select: UBRG_SRC_MCK,
    mode:                UBRG_MODE_ASYNC,
    over:                1'b0,
    divide_count:        CD_OFF
  };

endpackage

// [verilog/ubrg_core.sv]
// Baud rate generator: source select, divide count and oversampling stages.
module ubrg_core #(
  parameter int unsigned PRESCALE = ubrg_pkg::PRESCALE_DIV
) (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_pclk_en,
  input  wire logic               i_cfg_wr,
  input  wire ubrg_pkg::ubrg_cfg_t i_cfg,
  input  wire logic               i_sck_pin,
  output logic                    o_baud_tick,
  output logic                    o_sample_tick,
  output logic                    o_active,
  output logic                    o_bypass
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  localparam int unsigned PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
  localparam logic [PRE_W-1:0] PRE_STEP = PRE_W'(1);
  localparam logic [PRE_W-1:0] PRE_ZERO = '0;
  localparam logic [ubrg_pkg::OVS_W-1:0] OVS_STEP = ubrg_pkg::OVS_W'(1);
  localparam logic [ubrg_pkg::OVS_W-1:0] OVS_ZERO = '0;

  // Wraps a pulse counter; a limit lowered under the count wraps at once.
  function automatic logic at_last(input logic [15:0] cnt,
                                   input logic [15:0] last);
    at_last = (cnt >= last);
  endfunction

  // ---------------------------------------------------------------
  // Configuration holding
  // ---------------------------------------------------------------
  ubrg_pkg::ubrg_cfg_t cfg_r;

  // Writes bypass gating.
  // The peripheral clock enable is deliberately not consulted here so
  // that setup can complete before the enable is switched on.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_r <= ubrg_pkg::CFG_RESET;
    end else if (i_cfg_wr) begin
      cfg_r <= i_cfg;
    end
  end

  logic        is_async;
  logic        is_spi;
  logic        ext_direct;
  logic [15:0] cd;

  assign cd       = cfg_r.divide_count;
  assign is_async = (cfg_r.mode == ubrg_pkg::UBRG_MODE_ASYNC);
  assign is_spi   = (cfg_r.mode == ubrg_pkg::UBRG_MODE_SPI);

  assign ext_direct = !is_async
                   && (cfg_r.clock_source_select == ubrg_pkg::UBRG_SRC_EXT);

  // ---------------------------------------------------------------
  // Serial clock pin synchroniser
  // ---------------------------------------------------------------
  logic sck_meta_r;
  logic sck_sync_r;
  logic sck_prev_r;
  logic ext_rise;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_meta_r <= 1'b0;
      sck_sync_r <= 1'b0;
    end else begin
      sck_meta_r <= i_sck_pin;
      sck_sync_r <= sck_meta_r;
    end
  end

  // Edge history frozen.
  // The previous level only moves while enabled, so an edge seen while
  // stopped is taken on resume rather than lost or doubled.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_prev_r <= 1'b0;
    end else if (i_pclk_en) begin
      sck_prev_r <= sck_sync_r;
    end
  end

  // Phase width reliance.
  // Detection depends on each pin phase covering a full system period;
  // shorter phases may be missed by the two-stage synchroniser.
  assign ext_rise = i_pclk_en && sck_sync_r && !sck_prev_r;

  // ---------------------------------------------------------------
  // Fixed prescaler
  // ---------------------------------------------------------------
  logic [PRE_W-1:0] pre_cnt_r;
  logic             pre_tick;

  // The prescaler runs free while enabled, so the first divided pulse after
  // selecting it may come early; every later period is whole.
  assign pre_tick = i_pclk_en && (pre_cnt_r == PRE_LAST);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_cnt_r <= PRE_ZERO;
    end else if (i_pclk_en) begin
      if (pre_cnt_r == PRE_LAST) begin
        pre_cnt_r <= PRE_ZERO;
      end else begin
        pre_cnt_r <= pre_cnt_r + PRE_STEP;
      end
    end
  end

  // ---------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------
  logic src_tick;

  // Source code 2 is reserved and yields no pulses, so a stray write to it
  // stalls the link quietly instead of running it at an unexpected rate.
  // Source select.
  always_comb begin
    case (cfg_r.clock_source_select)
      ubrg_pkg::UBRG_SRC_MCK: begin
        src_tick = i_pclk_en;
      end
      ubrg_pkg::UBRG_SRC_DIV: begin
        src_tick = pre_tick;
      end
      ubrg_pkg::UBRG_SRC_EXT: begin
        src_tick = ext_rise;
      end
      default: begin
        src_tick = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Divide count stage
  // ---------------------------------------------------------------
  logic [15:0] cd_cnt_r;
  logic        div_tick;

  always_comb begin
    if (cd == ubrg_pkg::CD_OFF) begin
      div_tick = 1'b0;
    end else if (cd == ubrg_pkg::CD_BYPASS) begin
      div_tick = src_tick;
    end else begin
      div_tick = src_tick && at_last(cd_cnt_r, cd - ubrg_pkg::CD_STEP);
    end
  end

  // Programmable count.
  // The counter idles at zero while bypassed or off, so the first period
  // after a later count is programmed is always whole.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cd_cnt_r <= ubrg_pkg::CD_OFF;
    end else if (cd == ubrg_pkg::CD_OFF || cd == ubrg_pkg::CD_BYPASS) begin
      cd_cnt_r <= ubrg_pkg::CD_OFF;
    end else if (src_tick) begin
      if (at_last(cd_cnt_r, cd - ubrg_pkg::CD_STEP)) begin
        cd_cnt_r <= ubrg_pkg::CD_OFF;
      end else begin
        cd_cnt_r <= cd_cnt_r + ubrg_pkg::CD_STEP;
      end
    end
  end

  // ---------------------------------------------------------------
  // Oversampling stage
  // ---------------------------------------------------------------
  logic [ubrg_pkg::OVS_W-1:0] ovs_cnt_r;
  logic [ubrg_pkg::OVS_W-1:0] ovs_last;
  logic                       ovs_wrap;

  // A switch from 16x to 8x can leave the counter above the new limit; the
  // compare wraps it at the next sampling pulse rather than at the top.
  // Oversample rate.
  assign ovs_last = cfg_r.over ? ubrg_pkg::OVS_LAST_X8 : ubrg_pkg::OVS_LAST_X16;
  assign ovs_wrap = at_last(16'(ovs_cnt_r), 16'(ovs_last));

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovs_cnt_r <= OVS_ZERO;
    end else if (!is_async) begin
      ovs_cnt_r <= OVS_ZERO;
    end else if (div_tick) begin
      if (ovs_wrap) begin
        ovs_cnt_r <= OVS_ZERO;
      end else begin
        ovs_cnt_r <= ovs_cnt_r + OVS_STEP;
      end
    end
  end

  // ---------------------------------------------------------------
  // Bit-period selection
  // ---------------------------------------------------------------
  logic baud_raw;

  always_comb begin
    if (is_async) begin
      baud_raw = div_tick && ovs_wrap;
    end else if (ext_direct) begin
      baud_raw = src_tick;
    end else begin
      baud_raw = div_tick;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral interface rate ceiling
  // ---------------------------------------------------------------
  logic [ubrg_pkg::GAP_W-1:0] gap_cnt_r;
  logic                       gap_ok;
  logic                       baud_ok;

  // Quarter-rate ceiling.
  // A too-fast setting loses ticks instead of overrunning the link; the
  // remaining ticks then come slower than programmed, so software must still program
  // a legal count.
  assign gap_ok  = !is_spi || (gap_cnt_r == ubrg_pkg::GAP_READY);
  assign baud_ok = baud_raw && gap_ok;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gap_cnt_r <= ubrg_pkg::GAP_READY;
    end else if (i_pclk_en) begin
      if (baud_ok) begin
        gap_cnt_r <= ubrg_pkg::GAP_RESET;
      end else if (gap_cnt_r != ubrg_pkg::GAP_READY) begin
        gap_cnt_r <= gap_cnt_r + ubrg_pkg::GAP_STEP;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // Every output is registered, so a user sees each tick one cycle after
  // the stage that made it; both directions see the same delay.
  // Shared bit tick.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_baud_tick <= 1'b0;
    end else begin
      o_baud_tick <= baud_ok;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sample_tick <= 1'b0;
    end else begin
      o_sample_tick <= is_async && div_tick;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_active <= 1'b0;
      o_bypass <= 1'b0;
    end else begin
      o_active <= ext_direct || (cd != ubrg_pkg::CD_OFF);
      o_bypass <= !ext_direct && (cd == ubrg_pkg::CD_BYPASS);
    end
  end

endmodule // ubrg_core

// [verif/ubrg_core_props.sv]
// Port checker for the baud rate generator.
module ubrg_core_props #(
  parameter int unsigned PRESCALE = ubrg_pkg::PRESCALE_DIV
) (
  input wire logic                i_clk,
  input wire logic                i_resetn,
  input wire logic                i_pclk_en,
  input wire logic                i_cfg_wr,
  input wire ubrg_pkg::ubrg_cfg_t i_cfg,
  input wire logic                i_sck_pin,
  input wire logic                o_baud_tick,
  input wire logic                o_sample_tick,
  input wire logic                o_active,
  input wire logic                o_bypass
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Mode tracking
  // ---------------------------------------------------------------
  logic async_r;
  logic spi_r;

  // Mode as the tick logic sees it, one edge after the write.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      async_r <= 1'b1;
      spi_r   <= 1'b0;
    end else if (i_cfg_wr) begin
      async_r <= i_cfg.mode == ubrg_pkg::UBRG_MODE_ASYNC;
      spi_r   <= i_cfg.mode == ubrg_pkg::UBRG_MODE_SPI;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  AST_RESET_QUIET: assert property ($rose(i_resetn) |-> !o_baud_tick && !o_active)
    else $error("tick or active right after reset");
  AST_FROZEN: assert property (!i_pclk_en |=> !o_baud_tick && !o_sample_tick)
    else $error("tick while clock stopped");
  AST_CFG_ACTIVE: assert property (
    (i_cfg_wr && i_cfg.divide_count != 16'h0000) ##1 !i_cfg_wr |-> ##1 o_active)
    else $error("active not set");
  AST_CFG_BYPASS: assert property (
    (i_cfg_wr && i_cfg.divide_count == 16'h0001
    && i_cfg.clock_source_select != ubrg_pkg::UBRG_SRC_EXT) ##1 !i_cfg_wr |-> ##1 o_bypass)
    else $error("bypass not set");
  AST_CFG_OFF: assert property (
    (i_cfg_wr && i_cfg.divide_count == 16'h0000
    && (i_cfg.mode == ubrg_pkg::UBRG_MODE_ASYNC
    || i_cfg.clock_source_select != ubrg_pkg::UBRG_SRC_EXT)) ##1 !i_cfg_wr
    |-> ##1 !o_active[*3])
    else $error("active with zero count");
  AST_ASYNC_BAUD: assert property (
    o_baud_tick && async_r && $past(async_r) |-> o_sample_tick)
    else $error("baud without sample");
  AST_SYNC_NO_SAMPLE: assert property (
    !async_r && !$past(async_r) |-> !o_sample_tick)
    else $error("sample tick outside async");
  AST_SPI_GAP: assert property (
    o_baud_tick && spi_r && $past(spi_r) |=> !o_baud_tick[*3])
    else $error("serial clock too fast");
endmodule // ubrg_core_props

bind ubrg_core ubrg_core_props #(.PRESCALE(PRESCALE)) i_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_pclk_en(i_pclk_en), .i_cfg_wr(i_cfg_wr),
  .i_cfg(i_cfg), .i_sck_pin(i_sck_pin), .o_baud_tick(o_baud_tick),
  .o_sample_tick(o_sample_tick), .o_active(o_active), .o_bypass(o_bypass));

// [verif/ubrg_sck_model.sv]
// Remote party driving the serial clock pin in bursts.
module ubrg_sck_model (
  output logic o_sck
);
  timeunit 1ns;
  timeprecision 1ps;
  // The clock stands low between bursts.
  initial o_sck = 1'b0;
  task automatic burst(input int n, input int half_ns);
    repeat (n) begin
      #(half_ns) o_sck = 1'b1;
      #(half_ns) o_sck = 1'b0;
    end
  endtask
endmodule // ubrg_sck_model

// [verif/ubrg_core_tb.sv]
// Self-checking bench for the baud rate generator.
module ubrg_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk;
  logic                rstn;
  logic                en;
  logic                wr;
  logic                sck;
  logic                bt;
  logic                st;
  logic                act;
  logic                byp;
  ubrg_pkg::ubrg_cfg_t cfg;
  int                  bad_count;
  int                  n_compared;
  int                  nb;
  int                  ns;

  ubrg_core #(.PRESCALE(2)) i_dut (
    .i_clk(clk), .i_resetn(rstn), .i_pclk_en(en), .i_cfg_wr(wr), .i_cfg(cfg),
    .i_sck_pin(sck), .o_baud_tick(bt), .o_sample_tick(st), .o_active(act), .o_bypass(byp));
  ubrg_sck_model i_rem (.o_sck(sck));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counting at the edge sees settled values from the cycle before.
  always @(posedge clk) begin
    nb += int'(bt === 1'b1);
    ns += int'(st === 1'b1);
  end

  task automatic end_of_test();
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // No interrupt line; ticks are one-cycle levels.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Exact divide counts keep rate error at zero.
  task automatic setc(input logic [1:0] s, input logic [1:0] m, input logic o,
                      input logic [15:0] c);
    @(negedge clk);
    cfg = '{ubrg_pkg::ubrg_src_t'(s), ubrg_pkg::ubrg_mode_t'(m), o, c};
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Cycles between ticks; the last of n gaps counts, so start-up phase drops out.
  task automatic per(input bit smp, input int n, input bit fz, output int p);
    for (int i = 0; i < n; i++) begin
      p = 0;
      do begin
        @(negedge clk);
        p++;
        if (fz && i == n - 1 && p == 5) en = 1'b0;
        if (fz && i == n - 1 && p == 25) en = 1'b1;
      end while ((smp ? st : bt) !== 1'b1 && p < 3000);
      if (p == 3000) begin
        bad_count++;
        end_of_test();
      end
    end
  endtask

  task automatic t_async();
    int p;
    setc(2'h0, 2'h0, 1'b0, 16'h0003);
    per(1'b0, 3, 1'b0, p);
    chk(p, 48);
    chk(act, 1'b1);
    per(1'b1, 3, 1'b0, p);
    chk(p, 3);
    setc(2'h0, 2'h0, 1'b1, 16'h0002);
    per(1'b0, 3, 1'b0, p);
    chk(p, 16);
  endtask

  task automatic t_div();
    int p;
    setc(2'h1, 2'h0, 1'b1, 16'h0001);
    per(1'b1, 3, 1'b0, p);
    chk(p, 2);
    per(1'b0, 3, 1'b0, p);
    chk(p, 16);
    chk(byp, 1'b1);
  endtask

  task automatic t_sync();
    int p;
    int b;
    setc(2'h0, 2'h1, 1'b0, 16'h0005);
    per(1'b0, 3, 1'b0, p);
    chk(p, 5);
    @(negedge clk);
    chk(bt, 1'b0);
    b = ns;
    repeat (30) @(negedge clk);
    chk(ns - b, 0);
    setc(2'h0, 2'h1, 1'b0, 16'h0001);
    per(1'b0, 3, 1'b0, p);
    chk(p, 1);
    setc(2'h0, 2'h2, 1'b0, 16'h0001);
    per(1'b0, 3, 1'b0, p);
    chk(p, 4);
  endtask

  task automatic t_off_ext();
    int b;
    setc(2'h0, 2'h0, 1'b0, 16'h0000);
    repeat (2) @(negedge clk);
    b = nb + ns;
    repeat (60) @(negedge clk);
    chk(nb + ns - b, 0);
    chk(act, 1'b0);
    setc(2'h2, 2'h1, 1'b0, 16'h0001);
    b = nb;
    repeat (30) @(negedge clk);
    chk(nb - b, 0);
    setc(2'h3, 2'h1, 1'b0, 16'h0000);
    b = nb;
    i_rem.burst(6, 24);
    repeat (10) @(negedge clk);
    chk(nb - b, 6);
    setc(2'h3, 2'h0, 1'b1, 16'h0002);
    b = ns;
    i_rem.burst(8, 24);
    repeat (10) @(negedge clk);
    chk(ns - b, 4);
  endtask

  task automatic t_power();
    int p;
    setc(2'h0, 2'h0, 1'b0, 16'h0001);
    per(1'b0, 3, 1'b1, p);
    chk(p, 36);
    @(negedge clk);
    en = 1'b0;
    setc(2'h0, 2'h1, 1'b0, 16'h0003);
    en = 1'b1;
    per(1'b0, 3, 1'b0, p);
    chk(p, 3);
  endtask

  initial begin
    rstn = 1'b0;
    en = 1'b1;
    wr = 1'b0;
    cfg = ubrg_pkg::CFG_RESET;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    t_async();
    t_div();
    t_sync();
    t_off_ext();
    t_power();
    end_of_test();
  end
endmodule // ubrg_core_tb
